// ===== core/gpio_port_regs.svh
// Register indices, field positions, reset values and bit masks of the port block
`ifndef GPIO_PORT_REGS_SVH
`define GPIO_PORT_REGS_SVH

// Register indices (byte address is four times the index)
`define IDX_A_DIR 14'h02C0
`define IDX_A_PIN 14'h02C2
`define IDX_A_LAT 14'h02C4
`define IDX_B_DIR 14'h02C6
`define IDX_B_PIN 14'h02C8
`define IDX_B_LAT 14'h02CA
`define IDX_D_DIR 14'h02D2
`define IDX_D_PIN 14'h02D4
`define IDX_D_LAT 14'h02D6
`define IDX_E_DIR 14'h02D8
`define IDX_E_PIN 14'h02DA
`define IDX_E_LAT 14'h02DC
`define IDX_F_DIR 14'h02DE
`define IDX_F_PIN 14'h02E0
`define IDX_F_LAT 14'h02E2
`define IDX_CN_EN 14'h0060
`define IDX_PU_EN 14'h0064
`define IDX_IRQ_STATUS 14'h0068
`define IDX_IRQ_MASK 14'h006A

// Direction reset values
`define RST_A_DIR 16'h0200
`define RST_B_DIR 16'h003F
`define RST_D_DIR 16'h0005
`define RST_E_DIR 16'h00FF
`define RST_F_DIR 16'h01C0

// Implemented bits per port
`define MASK_A 16'h0200
`define MASK_B 16'h00FF
`define MASK_D 16'h0001
`define MASK_E 16'h00FF
`define MASK_F 16'h01C0

// Status and mask field: shared change flag
`define BIT_CHANGE 0

`endif

// ===== core/gpio_port_pkg.sv
// Types shared by the port block
package gpio_port_pkg;

    localparam int PORTS = 5;
    localparam int CHANGE_INPUTS = 8;

    typedef logic [PORTS-1:0][15:0] port_words_t;

    typedef struct packed {
        port_words_t dir;
        port_words_t lat;
        logic [CHANGE_INPUTS-1:0] cn_en;
        logic [CHANGE_INPUTS-1:0] pu_en;
        logic [CHANGE_INPUTS-1:0] cn_seen;
        logic status;
        logic mask;
        logic ack;
        logic [15:0] rdat;
        logic irq;
        port_words_t pout;
        port_words_t oe_n;
    } gpio_state_t;

endpackage

// ===== core/pin_sync.sv
// Two-stage synchroniser for a group of pin levels
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic enable,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_state_t;

    sync_state_t st_r;
    sync_state_t st_nxt;

    // First stage feeds only the second
    always_comb begin
        st_nxt = st_r;
        st_nxt.stage1 = async_in;
        st_nxt.stage2 = st_r.stage1;
    end

    // Frozen while the enable is low
    always_ff @(posedge clock) begin
        if (reset) begin
            st_r <= '0;
        end else if (enable) begin
            st_r <= st_nxt;
        end
    end

    assign sync_out = st_r.stage2;
endmodule

// ===== core/gpio_port_change_notify.sv
// Parallel port block with change notification, Wishbone register slave
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps
`include "gpio_port_regs.svh"
module gpio_port_change_notify (
    input wire logic clock,
    input wire logic reset,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [15:0] port_a_in,
    output logic [15:0] port_a_out,
    output logic [15:0] port_a_oe_n,
    input wire logic [15:0] port_b_in,
    output logic [15:0] port_b_out,
    output logic [15:0] port_b_oe_n,
    input wire logic [15:0] port_d_in,
    output logic [15:0] port_d_out,
    output logic [15:0] port_d_oe_n,
    input wire logic [15:0] port_e_in,
    output logic [15:0] port_e_out,
    output logic [15:0] port_e_oe_n,
    input wire logic [15:0] port_f_in,
    output logic [15:0] port_f_out,
    output logic [15:0] port_f_oe_n,
    input wire logic [gpio_port_pkg::CHANGE_INPUTS-1:0] change_input,
    output logic [gpio_port_pkg::CHANGE_INPUTS-1:0] pullup_en,
    output logic change_wake,
    output logic irq
);
    import gpio_port_pkg::*;

    // Port order A, B, D, E, F
    localparam port_words_t MASK_C = {`MASK_F, `MASK_E, `MASK_D, `MASK_B, `MASK_A};
    localparam port_words_t RST_DIR_C = {`RST_F_DIR, `RST_E_DIR, `RST_D_DIR, `RST_B_DIR,
                                         `RST_A_DIR};
    localparam logic [PORTS-1:0][13:0] IDX_DIR_C = {`IDX_F_DIR, `IDX_E_DIR, `IDX_D_DIR,
                                                    `IDX_B_DIR, `IDX_A_DIR};
    localparam logic [PORTS-1:0][13:0] IDX_PIN_C = {`IDX_F_PIN, `IDX_E_PIN, `IDX_D_PIN,
                                                    `IDX_B_PIN, `IDX_A_PIN};
    localparam logic [PORTS-1:0][13:0] IDX_LAT_C = {`IDX_F_LAT, `IDX_E_LAT, `IDX_D_LAT,
                                                    `IDX_B_LAT, `IDX_A_LAT};

    gpio_state_t st_r;
    gpio_state_t st_nxt;
    port_words_t pin_raw;
    port_words_t pin_sync;
    logic [CHANGE_INPUTS-1:0] cn_sync;
    logic [13:0] idx;
    logic req;
    logic wr_go;
    logic [15:0] wmask;
    logic chg_any;
    logic status_clr;

    assign pin_raw = {port_f_in, port_e_in, port_d_in, port_b_in, port_a_in};

    // Pins and change inputs reach the clocked logic only after two stages
    pin_sync #(
        .WIDTH(PORTS * 16)
    ) u_pin_sync (
        .clock(clock),
        .reset(reset),
        .enable(ce),
        .async_in(pin_raw),
        .sync_out(pin_sync)
    );

    pin_sync #(
        .WIDTH(CHANGE_INPUTS)
    ) u_cn_sync (
        .clock(clock),
        .reset(reset),
        .enable(ce),
        .async_in(change_input),
        .sync_out(cn_sync)
    );

    // Bus request decode; byte lanes 0 and 1 carry the 16-bit registers
    assign idx = wb_adr_i[15:2];
    assign req = wb_cyc_i && wb_stb_i && !st_r.ack;
    assign wr_go = req && wb_we_i;
    assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // Plain flags for the checks; a sequence cannot be negated
    assign chg_any = |(st_r.cn_en & (cn_sync ^ st_r.cn_seen));
    assign status_clr = wr_go && wb_sel_i[0] && idx == `IDX_IRQ_STATUS && wb_dat_i[`BIT_CHANGE];

    // Next-state logic: bus, change detector, pin drivers
    always_comb begin
        st_nxt = st_r;
        st_nxt.ack = req;
        st_nxt.rdat = 16'h0000;
        for (int p = 0; p < PORTS; p++) begin
            if (req && idx == IDX_DIR_C[p]) begin
                st_nxt.rdat = st_r.dir[p] & MASK_C[p];
            end
            if (req && idx == IDX_PIN_C[p]) begin
                st_nxt.rdat = pin_sync[p] & MASK_C[p];
            end
            if (req && idx == IDX_LAT_C[p]) begin
                st_nxt.rdat = st_r.lat[p] & MASK_C[p];
            end
            if (wr_go && idx == IDX_DIR_C[p]) begin
                st_nxt.dir[p] = ((st_r.dir[p] & ~wmask) | (wb_dat_i[15:0] & wmask))
                                & MASK_C[p];
            end
            // Writes to the pin register land in the latch
            if (wr_go && (idx == IDX_PIN_C[p] || idx == IDX_LAT_C[p])) begin
                st_nxt.lat[p] = ((st_r.lat[p] & ~wmask) | (wb_dat_i[15:0] & wmask))
                                & MASK_C[p];
            end
        end
        if (req && idx == `IDX_CN_EN) begin
            st_nxt.rdat = {8'h00, st_r.cn_en};
        end
        if (req && idx == `IDX_PU_EN) begin
            st_nxt.rdat = {8'h00, st_r.pu_en};
        end
        if (req && idx == `IDX_IRQ_STATUS) begin
            st_nxt.rdat = {15'h0000, st_r.status};
        end
        if (req && idx == `IDX_IRQ_MASK) begin
            st_nxt.rdat = {15'h0000, st_r.mask};
        end
        if (wr_go && wb_sel_i[0] && idx == `IDX_CN_EN) begin
            st_nxt.cn_en = wb_dat_i[7:0];
        end
        if (wr_go && wb_sel_i[0] && idx == `IDX_PU_EN) begin
            st_nxt.pu_en = wb_dat_i[7:0];
        end
        if (wr_go && wb_sel_i[0] && idx == `IDX_IRQ_MASK) begin
            st_nxt.mask = wb_dat_i[`BIT_CHANGE];
        end
        if (wr_go && wb_sel_i[0] && idx == `IDX_IRQ_STATUS && wb_dat_i[`BIT_CHANGE]) begin
            st_nxt.status = 1'b0;
        end
        // Detection after the clear so a change in the clearing cycle is kept
        if (|(st_r.cn_en & (cn_sync ^ st_r.cn_seen))) begin
            st_nxt.status = 1'b1;
        end
        // Recapture every input, so enabling a pin later raises no stale change
        st_nxt.cn_seen = cn_sync;
        st_nxt.irq = st_nxt.status && st_nxt.mask;
        // Pad drivers; unimplemented bits never drive
        for (int p = 0; p < PORTS; p++) begin
            st_nxt.pout[p] = st_nxt.lat[p] & MASK_C[p];
            st_nxt.oe_n[p] = st_nxt.dir[p] | ~MASK_C[p];
        end
    end

    // State register, frozen while ce is low
    always_ff @(posedge clock) begin
        if (reset) begin
            st_r <= '0;
            st_r.dir <= RST_DIR_C & MASK_C;
            st_r.oe_n <= '1;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    // Clockless wake path: captured levels hold while clocks stop
    always_comb begin
        change_wake = |(st_r.cn_en & (change_input ^ st_r.cn_seen));
    end

    assign wb_ack_o = st_r.ack;
    assign wb_dat_o = {16'h0000, st_r.rdat};
    assign irq = st_r.irq;
    assign pullup_en = st_r.pu_en;
    assign port_a_out = st_r.pout[0];
    assign port_b_out = st_r.pout[1];
    assign port_d_out = st_r.pout[2];
    assign port_e_out = st_r.pout[3];
    assign port_f_out = st_r.pout[4];
    assign port_a_oe_n = st_r.oe_n[0];
    assign port_b_oe_n = st_r.oe_n[1];
    assign port_d_oe_n = st_r.oe_n[2];
    assign port_e_oe_n = st_r.oe_n[3];
    assign port_f_oe_n = st_r.oe_n[4];

    // Checks on the design's own behaviour
    sequence s_req_new;
        ce && wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    sequence s_write_latch_b;
        s_req_new ##0 (wb_we_i && idx == `IDX_B_LAT && wb_sel_i[1:0] == 2'b11);
    endsequence

    sequence s_change_seen;
        ce && |(st_r.cn_en & (cn_sync ^ st_r.cn_seen));
    endsequence

    sequence s_status_clear;
        ce && wr_go && wb_sel_i[0] && idx == `IDX_IRQ_STATUS && wb_dat_i[0];
    endsequence

    sequence s_write_pin_e;
        s_req_new ##0 (wb_we_i && idx == `IDX_E_PIN && wb_sel_i[1:0] == 2'b11);
    endsequence

    a_ack_follows_req: assert property (@(posedge clock) disable iff (reset)
        s_req_new |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single cycle after request");

    a_latch_write_read: assert property (@(posedge clock) disable iff (reset)
        s_write_latch_b |=> st_r.lat[1] == ($past(wb_dat_i[15:0]) & 16'h00FF))
        else $error("latch write not held or masked wrong");

    // Flag and registered interrupt rise on the same edge
    a_change_sets_flag: assert property (@(posedge clock) disable iff (reset)
        s_change_seen |=> st_r.status && (irq || !st_r.mask))
        else $error("enabled change did not set flag");

    a_flag_sticky: assert property (@(posedge clock) disable iff (reset)
        (st_r.status && !(ce && status_clr)) |=> st_r.status)
        else $error("change flag lost without clear");

    a_irq_gated: assert property (@(posedge clock) disable iff (reset)
        irq == (st_r.status && st_r.mask))
        else $error("interrupt output disagrees with flag and mask");

    a_sync_two_stage: assert property (@(posedge clock) disable iff (reset)
        (ce && $past(ce) && $past(ce, 2) && !$past(reset) && !$past(reset, 2))
        |-> cn_sync == $past(change_input, 2))
        else $error("change input not delayed by two stages");

    a_unimpl_b_off: assert property (@(posedge clock) disable iff (reset)
        port_b_oe_n[15:8] == 8'hFF && port_b_out[15:8] == 8'h00)
        else $error("unimplemented port B bits driven");

    a_unimpl_f_off: assert property (@(posedge clock) disable iff (reset)
        (port_f_oe_n | 16'h01C0) == 16'hFFFF && (port_f_out & 16'hFE3F) == 16'h0000)
        else $error("unimplemented port F bits driven");

    a_dir_sets_oe: assert property (@(posedge clock) disable iff (reset)
        (s_req_new ##0 (wb_we_i && idx == `IDX_E_DIR && wb_sel_i[0]))
        |=> port_e_oe_n[7:0] == $past(wb_dat_i[7:0]))
        else $error("direction write did not steer output enable");

    a_read_zero_high: assert property (@(posedge clock) disable iff (reset)
        (s_req_new ##0 (idx == `IDX_D_DIR || idx == `IDX_D_PIN))
        |=> wb_dat_o[31:1] == 31'h00000000)
        else $error("unimplemented port D bits read non-zero");

    a_pullup_write: assert property (@(posedge clock) disable iff (reset)
        (s_req_new ##0 (wb_we_i && idx == `IDX_PU_EN && wb_sel_i[0]))
        |=> pullup_en == $past(wb_dat_i[7:0]))
        else $error("pull-up enable not taken from write");

    a_wake_clockless: assert property (@(posedge clock) disable iff (reset)
        (st_r.cn_en[0] && change_input[0] != st_r.cn_seen[0]) |-> change_wake)
        else $error("wake not raised for enabled change");

    // Clearing and idling of the shared flag
    a_flag_clear: assert property (@(posedge clock) disable iff (reset)
        (s_status_clear ##0 !chg_any) |=> !st_r.status)
        else $error("change flag not cleared by write of one");

    a_flag_quiet: assert property (@(posedge clock) disable iff (reset)
        (ce && !st_r.status && !chg_any) |=> !st_r.status)
        else $error("change flag set without enabled change");

    a_recapture_all: assert property (@(posedge clock) disable iff (reset)
        ce |=> st_r.cn_seen == $past(cn_sync))
        else $error("captured levels not updated");

    a_pin_two_stage: assert property (@(posedge clock) disable iff (reset)
        (ce && $past(ce) && $past(ce, 2) && !$past(reset) && !$past(reset, 2))
        |-> pin_sync == $past(pin_raw, 2))
        else $error("pad levels not delayed by two stages");

    // A stopped clock must leave captured levels untouched
    a_ce_freezes: assert property (@(posedge clock) disable iff (reset)
        !ce |=> $stable(st_r) && $stable(cn_sync))
        else $error("state moved while clock enable low");

    a_wake_needs_en: assert property (@(posedge clock) disable iff (reset)
        st_r.cn_en == '0 |-> !change_wake)
        else $error("wake raised with all inputs disabled");

    a_pin_write_latch: assert property (@(posedge clock) disable iff (reset)
        s_write_pin_e
        |=> st_r.lat[3] == ($past(wb_dat_i[15:0]) & 16'h00FF))
        else $error("pin register write missed the latch");

    a_oe_follows_dir: assert property (@(posedge clock) disable iff (reset)
        ce |=> port_b_oe_n == (st_r.dir[1] | 16'hFF00))
        else $error("port B output enable disagrees with direction");

    a_out_follows_lat: assert property (@(posedge clock) disable iff (reset)
        ce |=> port_d_out == (st_r.lat[2] & 16'h0001))
        else $error("port D output disagrees with latch");

    a_cn_en_write: assert property (@(posedge clock) disable iff (reset)
        (s_req_new ##0 (wb_we_i && idx == `IDX_CN_EN && wb_sel_i[0]))
        |=> st_r.cn_en == $past(wb_dat_i[7:0]))
        else $error("change enable not taken from write");

    a_ack_needs_req: assert property (@(posedge clock) disable iff (reset)
        (ce && !(wb_cyc_i && wb_stb_i)) |=> !wb_ack_o)
        else $error("ack without request");

    a_read_high_zero: assert property (@(posedge clock) disable iff (reset)
        wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
        else $error("upper read half not zero");

    a_mask_write: assert property (@(posedge clock) disable iff (reset)
        (s_req_new ##0 (wb_we_i && idx == `IDX_IRQ_MASK && wb_sel_i[0]))
        |=> st_r.mask == $past(wb_dat_i[`BIT_CHANGE]))
        else $error("interrupt mask not taken from write");

    // Reads of the small ports never show missing bits
    a_b_dir_high_zero: assert property (@(posedge clock) disable iff (reset)
        (s_req_new ##0 (!wb_we_i && idx == `IDX_B_DIR))
        |=> wb_dat_o[15:8] == 8'h00)
        else $error("port B direction upper byte read non-zero");

    a_f_read_masked: assert property (@(posedge clock) disable iff (reset)
        (s_req_new ##0 (idx == `IDX_F_DIR || idx == `IDX_F_LAT))
        |=> (wb_dat_o[15:0] & 16'hFE3F) == 16'h0000)
        else $error("port F missing bits read non-zero");

endmodule

// ===== dv/board_model.sv
// Board model: port pads and change switches
`timescale 1ns/1ps
module board_pad (
    input wire logic clock,
    input wire logic [15:0] out,
    input wire logic [15:0] oe_n,
    input wire logic [15:0] ext,
    input wire logic [15:0] drv,
    output logic [15:0] level
);
    logic [15:0] float_r = 16'h0000;
    // Undriven pads wander, so a stale level never passes
    always @(posedge clock) float_r <= ~float_r;
    // Device drives where oe_n is low, else the board
    assign level = (~oe_n & out) | (oe_n & ((drv & ext) | (~drv & float_r)));
endmodule

module board_switch (
    input wire logic clock,
    input wire logic [7:0] pu,
    input wire logic [7:0] sw,
    input wire logic [7:0] drv,
    output logic [7:0] level
);
    logic [7:0] float_r = 8'h00;
    // Released switches float unless pulled up
    always @(posedge clock) float_r <= ~float_r;
    assign level = (drv & sw) | (~drv & (pu | float_r));
endmodule

// ===== dv/tb.sv
// Self-checking bench for the port block
`timescale 1ns/1ps
`include "gpio_port_regs.svh"
module tb;
    import gpio_port_pkg::*;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic ce = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [15:0] adr = 16'h0000;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] rdat;
    logic ack;
    logic [15:0] p_out [PORTS];
    logic [15:0] p_oe_n [PORTS];
    logic [15:0] p_in [PORTS];
    logic [15:0] ext [PORTS] = '{default: 16'h0000};
    logic [15:0] drv = 16'hFFFF;
    logic [7:0] sw = 8'h00;
    logic [7:0] cn_in;
    logic [7:0] pu;
    logic wake;
    logic irq;
    logic [15:0] q;
    int fail_count = 0;
    int total_checks = 0;
    logic [13:0] dir_i [PORTS] = '{`IDX_A_DIR, `IDX_B_DIR, `IDX_D_DIR, `IDX_E_DIR, `IDX_F_DIR};
    logic [15:0] msk [PORTS] = '{`MASK_A, `MASK_B, `MASK_D, `MASK_E, `MASK_F};
    logic [15:0] rdir [PORTS] = '{16'h0200, 16'h003F, 16'h0001, 16'h00FF, 16'h01C0};

    always #5 clock = ~clock;

    gpio_port_change_notify dut_u (
        .clock(clock),
        .reset(reset),
        .ce(ce),
        .wb_cyc_i(cyc),
        .wb_stb_i(stb),
        .wb_we_i(we),
        .wb_adr_i(adr),
        .wb_sel_i(4'h3),
        .wb_dat_i(wdat),
        .wb_dat_o(rdat),
        .wb_ack_o(ack),
        .port_a_in(p_in[0]),
        .port_a_out(p_out[0]),
        .port_a_oe_n(p_oe_n[0]),
        .port_b_in(p_in[1]),
        .port_b_out(p_out[1]),
        .port_b_oe_n(p_oe_n[1]),
        .port_d_in(p_in[2]),
        .port_d_out(p_out[2]),
        .port_d_oe_n(p_oe_n[2]),
        .port_e_in(p_in[3]),
        .port_e_out(p_out[3]),
        .port_e_oe_n(p_oe_n[3]),
        .port_f_in(p_in[4]),
        .port_f_out(p_out[4]),
        .port_f_oe_n(p_oe_n[4]),
        .change_input(cn_in),
        .pullup_en(pu),
        .change_wake(wake),
        .irq(irq)
    );

    // One board pad model per port
    for (genvar g = 0; g < PORTS; g++) begin : pads
        board_pad pad_u (.clock(clock), .out(p_out[g]), .oe_n(p_oe_n[g]), .ext(ext[g]),
            .drv(drv), .level(p_in[g]));
    end
    board_switch sw_u (.clock(clock), .pu(pu), .sw(sw), .drv(8'hFF), .level(cn_in));

    // Classic cycle; master waits for ack, then idles one cycle
    task automatic xfer(input logic [13:0] i, input logic w, input logic [15:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {i, 2'b00};
        wdat <= {16'h0000, d};
        do begin
            @(posedge clock);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) begin
            fail_count++;
            $display("wrong value ack expected 1 seen %b", ack);
        end
        chk("dat high", 16'h0000, rdat[31:16]);
        q = rdat[15:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clock);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic close_out();
        if (fail_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        tick(10);
        reset <= 1'b0;
        tick(1);
        // Per port: reset values, masking, drive and read back
        for (int p = 0; p < PORTS; p++) begin
            xfer(dir_i[p], 1'b0, 16'h0000);
            chk("dir reset", rdir[p], q);
            xfer(dir_i[p] + 14'd4, 1'b0, 16'h0000);
            chk("latch reset", 16'h0000, q);
            xfer(dir_i[p], 1'b1, 16'hFFFF);
            xfer(dir_i[p], 1'b0, 16'h0000);
            chk("dir bits", msk[p], q);
            xfer(dir_i[p] + 14'd4, 1'b1, 16'hFFFF);
            xfer(dir_i[p] + 14'd4, 1'b0, 16'h0000);
            chk("latch bits", msk[p], q);
            xfer(dir_i[p], 1'b1, 16'h0000);
            chk("oe_n", ~msk[p], p_oe_n[p]);
            chk("out", msk[p], p_out[p]);
            tick(4);
            xfer(dir_i[p] + 14'd2, 1'b0, 16'h0000);
            chk("pin driven", msk[p], q);
            xfer(dir_i[p] + 14'd2, 1'b1, 16'h0000);
            xfer(dir_i[p] + 14'd4, 1'b0, 16'h0000);
            chk("pin write", 16'h0000, q);
            xfer(dir_i[p], 1'b1, 16'hFFFF);
            ext[p] <= 16'hAAAA;
            tick(4);
            xfer(dir_i[p] + 14'd2, 1'b0, 16'h0000);
            chk("pin input", 16'hAAAA & msk[p], q);
        end
        // Upper byte unimplemented, lower byte outputs; direction read straight after write
        xfer(`IDX_B_DIR, 1'b1, 16'hFF00);
        xfer(`IDX_B_DIR, 1'b0, 16'h0000);
        chk("b dir", 16'h0000, q);
        chk("b oe_n", 16'hFF00, p_oe_n[1]);
        xfer(`IDX_B_LAT, 1'b1, 16'h00A5);
        tick(4);
        xfer(`IDX_B_PIN, 1'b0, 16'h0000);
        chk("b pin", 16'h00A5, q);
        // Unmapped place answers zero and ignores writes
        xfer(14'h0100, 1'b1, 16'hFFFF);
        xfer(14'h0100, 1'b0, 16'h1234);
        chk("unmapped", 16'h0000, q);
        xfer(`IDX_PU_EN, 1'b1, 16'h00A5);
        chk("pullup", 16'h00A5, {8'h00, pu});
        xfer(`IDX_PU_EN, 1'b0, 16'h0000);
        chk("pullup rd", 16'h00A5, q);
        xfer(`IDX_PU_EN, 1'b1, 16'h0000);
        xfer(`IDX_IRQ_MASK, 1'b1, 16'h0001);
        // Each input alone: a disabled neighbour is ignored
        for (int i = 0; i < CHANGE_INPUTS; i++) begin
            xfer(`IDX_CN_EN, 1'b1, 16'h0001 << i);
            xfer(`IDX_IRQ_STATUS, 1'b1, 16'h0001);
            sw[(i + 1) % 8] <= ~sw[(i + 1) % 8];
            tick(8);
            chk("irq off", 16'h0000, {15'h0000, irq});
            sw[i] <= ~sw[i];
            tick(6);
            chk("irq on", 16'h0001, {15'h0000, irq});
            xfer(`IDX_IRQ_STATUS, 1'b0, 16'h0000);
            chk("status", 16'h0001, q & 16'h0001);
            xfer(`IDX_IRQ_STATUS, 1'b1, 16'h0001);
            tick(1);
            chk("irq clear", 16'h0000, {15'h0000, irq});
        end
        // Clock stopped: detection still seen on the wake line
        xfer(`IDX_CN_EN, 1'b1, 16'h0001);
        ce <= 1'b0;
        sw[0] <= ~sw[0];
        tick(3);
        chk("wake", 16'h0001, {15'h0000, wake});
        ce <= 1'b1;
        tick(6);
        chk("wake irq", 16'h0001, {15'h0000, irq});
        chk("recapture", 16'h0000, {15'h0000, wake});
        xfer(`IDX_IRQ_MASK, 1'b1, 16'h0000);
        tick(1);
        chk("masked", 16'h0000, {15'h0000, irq});
        close_out();
    end

    // Watchdog far beyond the expected run
    initial begin
        #200000;
        fail_count++;
        close_out();
    end
endmodule
